//--- rtl/sbl_ctrl_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbl_ctrl_defs.svh"

module sbl_ctrl_dev
#(
	parameter logic [15:0] CHIP_VERSION  = 16'h00A5,  // arbitrary value
	parameter logic [15:0] CHIP_REVISION = 16'h0000,  // first silicon
	parameter int          CYC_CNT_W     = 13,
	parameter logic [2:0]  ISO_TX_CHANS  = 3'h4
)
(
	input  wire logic                 mclk_in,
	input  wire logic                 rst_b_in,
	sbl_host_if.dev                   bus,
	input  wire logic                 phy_bus_reset_req_in,
	input  wire logic                 direct_couple_sel_in,
	input  wire logic                 phy_clk_tick_in,
	input  wire logic                 external_cycle_tick_in,
	input  wire logic                 cycle_start_rx_in,
	input  wire logic [CYC_CNT_W-1:0] cycle_start_rx_count_in,
	output logic                      tx_enable_out,
	output logic                      rx_enable_out,
	output logic                      lps_out,
	output logic                      phy_if_init_timing_sel_out,
	output logic [CYC_CNT_W-1:0]      cycle_count_out,
	output logic                      cycle_start_send_out,
	output logic                      cycle_timer_adjust_out,
	output logic [1:0]                iso_tx_mode_out,
	output logic [1:0]                iso_rx_mode_out,
	output logic [2:0]                iso_tx_max_chan_out,
	output logic [2:0]                iso_rx_max_chan_out,
	output logic                      iso_rx_split_out,
	output logic                      buffer_little_endian_out,
	output logic [1:0]                dma_beat_width_out
);

	localparam logic [3:0]  LPS_PERIOD = 4'(`SBL_LPS_PERIOD);
	localparam logic [3:0]  LPS_HIGH   = 4'(`SBL_LPS_HIGH);
	localparam logic [11:0] CYC_TICKS  = 12'(`SBL_CYC_TICKS);

	typedef struct packed
	{
		logic [31:0]          ctrl;
		logic [31:0]          rdata;
		logic                 rvalid;
		logic [3:0]           lps_cnt;
		logic                 lps;
		logic                 tick_prev;
		logic [11:0]          cyc_ofs;
		logic [CYC_CNT_W-1:0] cyc_cnt;
		logic                 cyc_start;
		logic                 cyc_adj;
		logic [1:0]           tx_mode;
		logic [1:0]           rx_mode;
		logic [2:0]           tx_max;
		logic [2:0]           rx_max;
		logic                 rx_split;
	} sbl_dev_state_t;

	localparam sbl_dev_state_t DEV_RST = '{ctrl: `SBL_CTRL_RST, default: '0};

	sbl_dev_state_t state_r;
	sbl_dev_state_t state_nxt;

	logic [4:0]  sh;
	logic [31:0] lane_m;
	logic [31:0] wr_m;
	logic [31:0] id_word;
	logic [2:0]  iso;
	logic        cyc_carry;
	logic        cyc_step;

	always_comb
	begin
		state_nxt = state_r;
		sh        = sbl_pkg::sbl_lane_shift(bus.bus_width, bus.addr[1:0]);
		lane_m    = sbl_pkg::sbl_lane_mask(bus.bus_width);
		wr_m      = (lane_m << sh) & `SBL_CTRL_WMASK;
		id_word   = {CHIP_VERSION, CHIP_REVISION};

		// register writes; the identification word has no storage to hit
		if (bus.wr && (bus.addr[7:2] == 6'(`SBL_CTRL_OFS >> 2)))
			state_nxt.ctrl = (state_r.ctrl & ~wr_m) | ((bus.wdata << sh) & wr_m);
		// bus reset request wins over any software write
		if (phy_bus_reset_req_in)
			state_nxt.ctrl[`SBL_TX_EN_BIT] = 1'b1;

		state_nxt.rvalid = bus.rd;
		state_nxt.rdata  = 32'h0000_0000;
		if (bus.rd)
		begin
			if (bus.addr[7:2] == 6'(`SBL_ID_OFS >> 2))
				state_nxt.rdata = (id_word >> sh) & lane_m;
			else if (bus.addr[7:2] == 6'(`SBL_CTRL_OFS >> 2))
				state_nxt.rdata = (state_r.ctrl >> sh) & lane_m;
		end

		// link power status output
		state_nxt.lps_cnt = (state_r.lps_cnt >= LPS_PERIOD - 4'h1) ? 4'h0
			: state_r.lps_cnt + 4'h1;
		if (!state_r.ctrl[`SBL_LPS_REQ_BIT])
			state_nxt.lps = 1'b0;
		else if (direct_couple_sel_in)
			state_nxt.lps = 1'b1;
		else
			state_nxt.lps = (state_r.lps_cnt < LPS_HIGH);

		// cycle timer; an external tick counts a whole cycle per rising edge
		state_nxt.tick_prev = external_cycle_tick_in;
		cyc_step  = 1'b0;
		cyc_carry = 1'b0;
		if (state_r.ctrl[`SBL_CYC_SRC_BIT])
			cyc_carry = external_cycle_tick_in && !state_r.tick_prev;
		else
			cyc_step = phy_clk_tick_in;
		if (!state_r.ctrl[`SBL_CYC_EN_BIT])
		begin
			cyc_step  = 1'b0;
			cyc_carry = 1'b0;
		end
		if (cyc_step)
		begin
			if (state_r.cyc_ofs == CYC_TICKS - 12'h001)
			begin
				state_nxt.cyc_ofs = 12'h000;
				cyc_carry         = 1'b1;
			end
			else
				state_nxt.cyc_ofs = state_r.cyc_ofs + 12'h001;
		end
		if (cyc_carry)
			state_nxt.cyc_cnt = state_r.cyc_cnt + 1'b1;
		state_nxt.cyc_start = cyc_carry && state_r.ctrl[`SBL_CYC_ROOT_BIT]
			&& state_r.ctrl[`SBL_TX_EN_BIT];
		state_nxt.cyc_adj = 1'b0;
		// a non-root node slaves its timer to the received cycle start
		if (!state_r.ctrl[`SBL_CYC_ROOT_BIT] && cycle_start_rx_in
			&& state_r.ctrl[`SBL_RX_EN_BIT])
		begin
			state_nxt.cyc_ofs = 12'h000;
			state_nxt.cyc_cnt = cycle_start_rx_count_in;
			state_nxt.cyc_adj = 1'b1;
		end

		// isochronous mode decode
		iso = state_r.ctrl[`SBL_ISO_MODE_MSB:`SBL_ISO_MODE_LSB];
		state_nxt.tx_mode  = sbl_pkg::SBL_XFER_OFF;
		state_nxt.rx_mode  = sbl_pkg::SBL_XFER_OFF;
		state_nxt.rx_split = 1'b0;
		unique case (iso)
			`SBL_ISO_NN:
			begin
				state_nxt.tx_mode = sbl_pkg::SBL_XFER_NORMAL;
				state_nxt.rx_mode = sbl_pkg::SBL_XFER_NORMAL;
			end
			`SBL_ISO_NA:
			begin
				state_nxt.tx_mode = sbl_pkg::SBL_XFER_NORMAL;
				state_nxt.rx_mode = sbl_pkg::SBL_XFER_AUTO;
			end
			`SBL_ISO_AN:
			begin
				state_nxt.tx_mode = sbl_pkg::SBL_XFER_AUTO;
				state_nxt.rx_mode = sbl_pkg::SBL_XFER_NORMAL;
			end
			`SBL_ISO_XA:
			begin
				state_nxt.rx_mode  = sbl_pkg::SBL_XFER_AUTO;
				state_nxt.rx_split = 1'b1;
			end
			`SBL_ISO_AA:
			begin
				state_nxt.tx_mode = sbl_pkg::SBL_XFER_AUTO;
				state_nxt.rx_mode = sbl_pkg::SBL_XFER_AUTO;
			end
			`SBL_ISO_XN:
				state_nxt.rx_mode = sbl_pkg::SBL_XFER_NORMAL;
			// reserved codes leave both directions off
			default:
			begin
				state_nxt.tx_mode = sbl_pkg::SBL_XFER_OFF;
				state_nxt.rx_mode = sbl_pkg::SBL_XFER_OFF;
			end
		endcase

		// channel limits; normal tx sends at most one packet per channel each cycle
		state_nxt.tx_max = 3'h0;
		if (state_nxt.tx_mode == sbl_pkg::SBL_XFER_NORMAL)
			state_nxt.tx_max = ISO_TX_CHANS;
		else if (state_nxt.tx_mode == sbl_pkg::SBL_XFER_AUTO)
			state_nxt.tx_max = `SBL_TX_MAX_AUTO;
		state_nxt.rx_max = 3'h0;
		if (state_nxt.rx_mode == sbl_pkg::SBL_XFER_NORMAL)
			state_nxt.rx_max = (iso == `SBL_ISO_AN) ? `SBL_RX_MAX_AN
				: `SBL_RX_MAX_NORM;
		else if (state_nxt.rx_mode == sbl_pkg::SBL_XFER_AUTO)
			state_nxt.rx_max = (iso == `SBL_ISO_XA) ? `SBL_RX_MAX_XA
				: `SBL_RX_MAX_AUTO;
		// receive disabled means no channel is taken
		if (!state_r.ctrl[`SBL_RX_EN_BIT])
			state_nxt.rx_max = 3'h0;
		// transmit disabled means no isochronous channel is sent
		if (!state_r.ctrl[`SBL_TX_EN_BIT])
			state_nxt.tx_max = 3'h0;
	end

	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			state_r <= DEV_RST;
		else
			state_r <= state_nxt;
	end

	assign bus.rdata  = state_r.rdata;
	assign bus.rvalid = state_r.rvalid;

	assign tx_enable_out              = state_r.ctrl[`SBL_TX_EN_BIT];
	assign rx_enable_out              = state_r.ctrl[`SBL_RX_EN_BIT];
	assign lps_out                    = state_r.lps;
	assign phy_if_init_timing_sel_out = state_r.ctrl[`SBL_PHY_INIT_BIT];
	assign cycle_count_out            = state_r.cyc_cnt;
	assign cycle_start_send_out       = state_r.cyc_start;
	assign cycle_timer_adjust_out     = state_r.cyc_adj;
	assign iso_tx_mode_out            = state_r.tx_mode;
	assign iso_rx_mode_out            = state_r.rx_mode;
	assign iso_tx_max_chan_out        = state_r.tx_max;
	assign iso_rx_max_chan_out        = state_r.rx_max;
	assign iso_rx_split_out           = state_r.rx_split;
	assign buffer_little_endian_out   = state_r.ctrl[`SBL_LITTLE_BIT];
	assign dma_beat_width_out = state_r.ctrl[`SBL_DMA_W_MSB:`SBL_DMA_W_LSB];

endmodule

`default_nettype wire

//--- pkg/sbl_ctrl_defs.svh
`ifndef SBL_CTRL_DEFS_SVH
`define SBL_CTRL_DEFS_SVH

// register byte offsets
`define SBL_ID_OFS          8'h00
`define SBL_CTRL_OFS        8'h04

`define SBL_CTRL_RST        32'h0003_0001
// writable bits of the control word; the rest read as zero
`define SBL_CTRL_WMASK      32'h3177_0093

`define SBL_TX_EN_BIT       0
`define SBL_RX_EN_BIT       1
`define SBL_LPS_REQ_BIT     4
`define SBL_PHY_INIT_BIT    7
`define SBL_CYC_EN_BIT      16
`define SBL_CYC_ROOT_BIT    17
`define SBL_CYC_SRC_BIT     18
`define SBL_ISO_MODE_LSB    20
`define SBL_ISO_MODE_MSB    22
`define SBL_LITTLE_BIT      24
`define SBL_DMA_W_LSB       28
`define SBL_DMA_W_MSB       29

// iso mode codes
`define SBL_ISO_NN          3'h0
`define SBL_ISO_NA          3'h1
`define SBL_ISO_AN          3'h2
`define SBL_ISO_XA          3'h3
`define SBL_ISO_AA          3'h4
`define SBL_ISO_XN          3'h5

`define SBL_RX_MAX_NORM     3'h4
`define SBL_RX_MAX_AN       3'h3
`define SBL_RX_MAX_AUTO     3'h1
`define SBL_RX_MAX_XA       3'h2
`define SBL_TX_MAX_AUTO     3'h1

// timing: clock and link power clock in kHz
`define SBL_CLK_KHZ         20000
`define SBL_LPS_TARGET_KHZ  2200
`define SBL_LPS_PERIOD      (`SBL_CLK_KHZ / `SBL_LPS_TARGET_KHZ)
`define SBL_LPS_HIGH        (`SBL_LPS_PERIOD / 3)
`define SBL_PHY_CLK_KHZ     24576
`define SBL_ISO_CYCLE_KHZ   8
`define SBL_CYC_TICKS       (`SBL_PHY_CLK_KHZ / `SBL_ISO_CYCLE_KHZ)

`endif

//--- pkg/sbl_pkg.sv
package sbl_pkg;

	typedef enum logic [1:0]
	{
		SBL_BUS_8  = 2'h0,
		SBL_BUS_16 = 2'h1,
		SBL_BUS_32 = 2'h2
	} sbl_bus_width_t;

	typedef enum logic [1:0]
	{
		SBL_XFER_OFF    = 2'h0,
		SBL_XFER_NORMAL = 2'h1,
		SBL_XFER_AUTO   = 2'h2
	} sbl_iso_xfer_t;

	typedef enum logic [1:0]
	{
		SBL_H_IDLE   = 2'h0,
		SBL_H_STROBE = 2'h1,
		SBL_H_WAIT   = 2'h3,
		SBL_H_DONE   = 2'h2
	} sbl_host_state_t;

	// bit position of the register slice carried by a beat at this address
	function automatic logic [4:0] sbl_lane_shift(input logic [1:0] width,
		input logic [1:0] addr_lo);
		logic [4:0] sh;
		sh = 5'h00;
		if (width == SBL_BUS_8)
			sh = 5'h18 - {addr_lo, 3'h0};
		else if (width == SBL_BUS_16)
			sh = addr_lo[1] ? 5'h00 : 5'h10;
		return sh;
	endfunction

	function automatic logic [31:0] sbl_lane_mask(input logic [1:0] width);
		logic [31:0] m;
		m = 32'hFFFF_FFFF;
		if (width == SBL_BUS_8)
			m = 32'h0000_00FF;
		else if (width == SBL_BUS_16)
			m = 32'h0000_FFFF;
		return m;
	endfunction

endpackage

//--- pkg/sbl_host_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sbl_host_if;
	logic [1:0]  bus_width;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        rvalid;

	modport dev
	(
		input  bus_width,
		input  addr,
		input  wdata,
		input  wr,
		input  rd,
		output rdata,
		output rvalid
	);

	modport host
	(
		output bus_width,
		output addr,
		output wdata,
		output wr,
		output rd,
		input  rdata,
		input  rvalid
	);
endinterface

`default_nettype wire

//--- rtl/sbl_ctrl_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbl_ctrl_defs.svh"

module sbl_ctrl_host
#(
	parameter logic [1:0] BUS_WIDTH = 2'h2
)
(
	input  wire logic        mclk_in,
	input  wire logic        rst_b_in,
	sbl_host_if.host         bus,
	input  wire logic        cmd_valid_in,
	input  wire logic        cmd_write_in,
	input  wire logic [7:0]  cmd_addr_in,
	input  wire logic [31:0] cmd_wdata_in,
	output logic             cmd_ready_out,
	output logic             rsp_valid_out,
	output logic [31:0]      rsp_rdata_out
);

	typedef struct packed
	{
		sbl_pkg::sbl_host_state_t st;
		logic [7:0]               base;
		logic [1:0]               beat;
		logic                     write;
		logic [31:0]              wdata;
		logic [31:0]              acc;
		logic [7:0]               addr;
		logic [31:0]              bus_wdata;
		logic                     wr;
		logic                     rd;
		logic                     ready;
		logic                     rsp;
	} sbl_host_regs_t;

	localparam sbl_host_regs_t HOST_RST = '{st: sbl_pkg::SBL_H_IDLE, ready: 1'b1,
		default: '0};

	sbl_host_regs_t state_r;
	sbl_host_regs_t state_nxt;

	logic [1:0]  last_beat;
	logic [1:0]  beat_n;
	logic [7:0]  beat_addr;
	logic [31:0] lane_m;
	logic [4:0]  sh_cur;
	logic [4:0]  sh_n;

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.wr  = 1'b0;
		state_nxt.rd  = 1'b0;
		state_nxt.rsp = 1'b0;
		lane_m    = sbl_pkg::sbl_lane_mask(BUS_WIDTH);
		last_beat = (BUS_WIDTH == sbl_pkg::SBL_BUS_8) ? 2'h3
			: (BUS_WIDTH == sbl_pkg::SBL_BUS_16) ? 2'h1 : 2'h0;
		beat_n    = state_r.beat + 2'h1;
		// narrow buses step through the word's byte addresses in order
		beat_addr = (BUS_WIDTH == sbl_pkg::SBL_BUS_16) ? {5'h00, beat_n, 1'b0}
			: {6'h00, beat_n};
		sh_cur = sbl_pkg::sbl_lane_shift(BUS_WIDTH, state_r.addr[1:0]);
		sh_n   = sbl_pkg::sbl_lane_shift(BUS_WIDTH, beat_addr[1:0]);
		unique case (state_r.st)
			sbl_pkg::SBL_H_IDLE:
				if (cmd_valid_in)
				begin
					state_nxt.base  = {cmd_addr_in[7:2], 2'h0};
					state_nxt.write = cmd_write_in;
					state_nxt.wdata = cmd_wdata_in;
					state_nxt.acc   = 32'h0000_0000;
					state_nxt.beat  = 2'h0;
					state_nxt.addr  = {cmd_addr_in[7:2], 2'h0};
					state_nxt.ready = 1'b0;
					state_nxt.bus_wdata = (cmd_wdata_in >> sbl_pkg::sbl_lane_shift(
						BUS_WIDTH, 2'h0)) & lane_m;
					// the identification word is never written
					if (cmd_write_in && (cmd_addr_in[7:2] == 6'(`SBL_ID_OFS >> 2)))
						state_nxt.st = sbl_pkg::SBL_H_DONE;
					else
					begin
						state_nxt.st = sbl_pkg::SBL_H_STROBE;
						state_nxt.wr = cmd_write_in;
						state_nxt.rd = !cmd_write_in;
					end
				end
			sbl_pkg::SBL_H_STROBE:
				if (!state_r.write)
					state_nxt.st = sbl_pkg::SBL_H_WAIT;
				else if (state_r.beat == last_beat)
					state_nxt.st = sbl_pkg::SBL_H_DONE;
				else
				begin
					state_nxt.beat      = beat_n;
					state_nxt.addr      = state_r.base | beat_addr;
					state_nxt.bus_wdata = (state_r.wdata >> sh_n) & lane_m;
					state_nxt.wr        = 1'b1;
				end
			sbl_pkg::SBL_H_WAIT:
				if (bus.rvalid)
				begin
					state_nxt.acc = state_r.acc | ((bus.rdata & lane_m) << sh_cur);
					if (state_r.beat == last_beat)
						state_nxt.st = sbl_pkg::SBL_H_DONE;
					else
					begin
						state_nxt.beat = beat_n;
						state_nxt.addr = state_r.base | beat_addr;
						state_nxt.rd   = 1'b1;
						state_nxt.st   = sbl_pkg::SBL_H_STROBE;
					end
				end
			sbl_pkg::SBL_H_DONE:
			begin
				state_nxt.rsp   = 1'b1;
				state_nxt.ready = 1'b1;
				state_nxt.st    = sbl_pkg::SBL_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			state_r <= HOST_RST;
		else
			state_r <= state_nxt;
	end

	assign bus.bus_width = BUS_WIDTH;
	assign bus.addr      = state_r.addr;
	assign bus.wdata     = state_r.bus_wdata;
	assign bus.wr        = state_r.wr;
	assign bus.rd        = state_r.rd;
	assign cmd_ready_out = state_r.ready;
	assign rsp_valid_out = state_r.rsp;
	assign rsp_rdata_out = state_r.acc;

endmodule

`default_nettype wire

//--- bench/sbl_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none

module sbl_ctrl_properties
#(
	parameter logic [15:0] CHIP_VERSION  = 16'h00A5,
	parameter logic [15:0] CHIP_REVISION = 16'h0000
)
(
	input  wire logic        mclk_in,
	input  wire logic        rst_b_in,
	input  wire logic [1:0]  bus_width,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	input  wire logic [31:0] rdata,
	input  wire logic        rvalid
);
	localparam logic [31:0] ID_WORD = {CHIP_VERSION, CHIP_REVISION};
	logic        fresh_r;
	logic        fresh_nxt;
	logic [31:0] lane_exp;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_b_in);

	// control word still holds its reset value until the first write to it
	always_comb
	begin
		fresh_nxt = fresh_r && !(wr && addr[7:2] == 6'h01);
	end

	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			fresh_r <= 1'b1;
		else
			fresh_r <= fresh_nxt;
	end

	always_comb
	begin
		lane_exp = ID_WORD;
		if (bus_width == 2'h0)
			lane_exp = (ID_WORD >> (6'h18 - {1'b0, addr[1:0], 3'h0})) & 32'h0000_00FF;
		else if (bus_width == 2'h1)
			lane_exp = addr[1] ? {16'h0, ID_WORD[15:0]} : {16'h0, ID_WORD[31:16]};
	end

	a_read_answer: assert property (rd |=> rvalid)
		else $error("read strobe not answered next cycle");
	a_no_stray_rvalid: assert property (rvalid |-> $past(rd))
		else $error("read answer without a read strobe");
	a_id_lanes: assert property (rd && addr[7:2] == 6'h00 |=> rdata == $past(lane_exp))
		else $error("identification beat on wrong lane");
	a_rev_first: assert property (rd && addr == 8'h00 && bus_width == 2'h2 |=> rdata[15:0] == 16'h0000)
		else $error("revision of first silicon not zero");
	a_ctrl_spare_zero: assert property (rd && addr[7:2] == 6'h01 && bus_width == 2'h2
		|=> (rdata & 32'hCE88_FF6C) == 32'h0)
		else $error("unassigned control bit reads one");
	a_ctrl_reset: assert property (rd && addr[7:2] == 6'h01 && bus_width == 2'h2 && fresh_r
		|=> rdata == 32'h0003_0001)
		else $error("control word not at reset value");
	a_no_id_write: assert property (wr |-> addr[7:2] != 6'h00)
		else $error("write strobe to identification word");
	a_unmapped_zero: assert property (rd && addr[7:2] > 6'h01 |=> rdata == 32'h0)
		else $error("unmapped read not zero");

	c_id_read: cover property (rd && addr[7:2] == 6'h00);
	c_ctrl_write: cover property (wr && addr[7:2] == 6'h01);
	c_answer: cover property (rvalid && rdata != 32'h0);
endmodule

`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	localparam logic [15:0] VER  = 16'h005A;  // arbitrary value
	localparam logic [31:0] ID_W = {VER, 16'h0000};
	localparam logic [1:0]  TXM[8] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h2, 2'h0, 2'h0, 2'h0};
	localparam logic [1:0]  RXM[8] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h2, 2'h1, 2'h0, 2'h0};
	logic        mclk_in  = 1'b0;
	logic        rst_b_in = 1'b0;
	logic        bus_rst  = 1'b0;
	logic        direct   = 1'b1;
	logic        phy_tick = 1'b0;
	logic        ext_tick = 1'b0;
	logic        cs_rx    = 1'b0;
	logic [12:0] cs_cnt   = 13'h0000;
	logic        cv[3];
	logic        cw[3];
	logic [7:0]  ca[3];
	logic [31:0] cd[3];
	wire         rdy[3], rv[3], tx[3], rx[3], lps[3], pinit[3], cs_send[3], adj[3];
	wire         split[3], little[3];
	wire [31:0]  rdat[3];
	wire [12:0]  cyc[3];
	wire [1:0]   txm[3], rxm[3], dma[3];
	wire [2:0]   txmax[3], rxmax[3];
	int          n_errors = 0;
	int          checked  = 0;
	int          cycles   = 0;

	sbl_host_if bus_if[3]();

	// pair 0 runs a 32-bit bus, pair 1 an 8-bit bus, pair 2 a 16-bit bus
	for (genvar g = 0; g < 3; g++)
	begin : g_pair
		sbl_ctrl_host #(.BUS_WIDTH(g == 0 ? 2'h2 : (g == 1 ? 2'h0 : 2'h1))) i_sbl_ctrl_host
		(
			.mclk_in(mclk_in), .rst_b_in(rst_b_in), .bus(bus_if[g]),
			.cmd_valid_in(cv[g]), .cmd_write_in(cw[g]), .cmd_addr_in(ca[g]),
			.cmd_wdata_in(cd[g]), .cmd_ready_out(rdy[g]), .rsp_valid_out(rv[g]),
			.rsp_rdata_out(rdat[g])
		);
		sbl_ctrl_dev #(.CHIP_VERSION(VER)) i_sbl_ctrl_dev
		(
			.mclk_in(mclk_in), .rst_b_in(rst_b_in), .bus(bus_if[g]),
			.phy_bus_reset_req_in(bus_rst), .direct_couple_sel_in(direct),
			.phy_clk_tick_in(phy_tick), .external_cycle_tick_in(ext_tick),
			.cycle_start_rx_in(cs_rx), .cycle_start_rx_count_in(cs_cnt),
			.tx_enable_out(tx[g]), .rx_enable_out(rx[g]), .lps_out(lps[g]),
			.phy_if_init_timing_sel_out(pinit[g]), .cycle_count_out(cyc[g]),
			.cycle_start_send_out(cs_send[g]), .cycle_timer_adjust_out(adj[g]),
			.iso_tx_mode_out(txm[g]), .iso_rx_mode_out(rxm[g]),
			.iso_tx_max_chan_out(txmax[g]), .iso_rx_max_chan_out(rxmax[g]),
			.iso_rx_split_out(split[g]), .buffer_little_endian_out(little[g]),
			.dma_beat_width_out(dma[g])
		);
	end

	sbl_ctrl_properties #(.CHIP_VERSION(VER), .CHIP_REVISION(16'h0000)) i_sbl_ctrl_properties
	(
		.mclk_in(mclk_in), .rst_b_in(rst_b_in), .bus_width(bus_if[0].bus_width),
		.addr(bus_if[0].addr), .wdata(bus_if[0].wdata), .wr(bus_if[0].wr),
		.rd(bus_if[0].rd), .rdata(bus_if[0].rdata), .rvalid(bus_if[0].rvalid)
	);

	initial
	begin
		forever #25 mclk_in = ~mclk_in;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one command through the host end; the port is idle and ready when this is entered
	task automatic cmd(input int p, input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int k;
		chk({31'h0, rdy[p]}, 32'h1);
		cv[p] = 1'b1;
		cw[p] = w;
		ca[p] = a;
		cd[p] = d;
		tick(1);
		cv[p] = 1'b0;
		chk({31'h0, rdy[p]}, 32'h0);
		k = 0;
		while (rv[p] !== 1'b1 && k < 40)
		begin
			tick(1);
			k++;
		end
		chk({31'h0, rv[p]}, 32'h1);
		q = rdat[p];
	endtask

	task automatic wrc(input int p, input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		cmd(p, 1'b1, a, d, q);
	endtask

	task automatic rdc(input int p, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		cmd(p, 1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	function automatic logic [31:0] outs(input int p);
		return {26'h0, tx[p], rx[p], pinit[p], little[p], dma[p]};
	endfunction

	task automatic t_reset();
		for (int p = 0; p < 3; p++)
		begin
			rdc(p, 8'h04, 32'h0003_0001);
			rdc(p, 8'h00, ID_W);
			rdc(p, 8'h10, 32'h0);
			chk(outs(p), 32'h20);
		end
		wrc(0, 8'h00, 32'hFFFF_FFFF);
		rdc(0, 8'h00, ID_W);
		$display("reset test done");
	endtask

	task automatic t_fields();
		wrc(1, 8'h04, 32'hFFFF_FFFF);
		rdc(1, 8'h04, 32'h3177_0093);
		chk(outs(1), 32'h3F);
		wrc(2, 8'h04, 32'h1000_0000);
		rdc(2, 8'h04, 32'h1000_0000);
		chk(outs(2), 32'h01);
		wrc(0, 8'h04, 32'h2100_0000);
		tick(1);
		chk(outs(0), 32'h06);
		$display("field test done");
	endtask

	task automatic t_iso();
		logic [2:0] tm;
		logic [2:0] rm;
		for (int c = 0; c < 8; c++)
		begin
			wrc(0, 8'h04, 32'h0003_0003 | (32'(c) << 20));
			tick(1);
			tm = TXM[c] == 2'h1 ? 3'h4 : {2'h0, TXM[c] == 2'h2};
			rm = RXM[c] == 2'h1 ? (c == 2 ? 3'h3 : 3'h4) : (RXM[c] == 2'h2 ? (c == 3 ? 3'h2 : 3'h1) : 3'h0);
			chk({21'h0, split[0], txmax[0], rxmax[0], txm[0], rxm[0]},
				{21'h0, c == 3, tm, rm, TXM[c], RXM[c]});
		end
		$display("iso mode test done");
	endtask

	task automatic t_bus_rst();
		wrc(0, 8'h04, 32'h0003_0000);
		chk({31'h0, tx[0]}, 32'h0);
		bus_rst = 1'b1;
		tick(1);
		bus_rst = 1'b0;
		tick(1);
		chk({31'h0, tx[0]}, 32'h1);
		rdc(0, 8'h04, 32'h0003_0001);
		$display("bus reset test done");
	endtask

	task automatic count_lps(input int n, output int hi);
		hi = 0;
		repeat (n)
		begin
			tick(1);
			if (lps[0] === 1'b1)
				hi++;
		end
	endtask

	task automatic t_lps();
		int hi;
		wrc(0, 8'h04, 32'h0003_0011);
		tick(1);
		count_lps(9, hi);
		chk(32'(hi), 32'h9);
		direct = 1'b0;
		tick(2);
		// 27 cycles span exactly three periods whatever the phase
		count_lps(27, hi);
		chk(32'(hi), 32'h9);
		wrc(0, 8'h04, 32'h0003_0001);
		count_lps(18, hi);
		chk(32'(hi), 32'h0);
		direct = 1'b1;
		$display("link power test done");
	endtask

	task automatic t_cycle();
		logic [12:0] c0;
		int n;
		for (int en = 1; en >= 0; en--)
		begin
			wrc(0, 8'h04, 32'h0002_0001 | (32'(en) << 16));
			c0 = cyc[0];
			n = 0;
			phy_tick = 1'b1;
			repeat (3075)
			begin
				tick(1);
				phy_tick = cyc[0] == c0;
				n += int'(cs_send[0] === 1'b1);
			end
			phy_tick = 1'b0;
			chk({19'h0, 13'(cyc[0] - c0)}, 32'(en));
			chk(32'(n), 32'(en));
		end
		wrc(0, 8'h04, 32'h0007_0000);
		c0 = cyc[0];
		n = 0;
		repeat (3)
		begin
			ext_tick = 1'b1;
			tick(1);
			// a start pulse would stand only in this cycle
			n += int'(cs_send[0] === 1'b1);
			tick(1);
			ext_tick = 1'b0;
			tick(2);
		end
		chk({19'h0, 13'(cyc[0] - c0)}, 32'h3);
		chk(32'(n), 32'h0);
		wrc(0, 8'h04, 32'h0001_0002);
		cs_cnt = 13'h0ABC;
		cs_rx = 1'b1;
		n = 0;
		repeat (4)
		begin
			tick(1);
			cs_rx = 1'b0;
			n += int'(adj[0] === 1'b1);
		end
		chk(32'(n), 32'h1);
		chk({19'h0, cyc[0]}, 32'h0ABC);
		$display("cycle timer test done");
	endtask

	task automatic finish_test();
		$display("checks=%0d errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// the tests need about 6400 cycles
	always @(posedge mclk_in)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			finish_test();
		end
	end

	initial
	begin
		for (int i = 0; i < 3; i++)
		begin
			cv[i] = 1'b0;
			cw[i] = 1'b0;
			ca[i] = 8'h00;
			cd[i] = 32'h0;
		end
		tick(12);
		rst_b_in = 1'b1;
		tick(1);
		t_reset();
		t_fields();
		t_iso();
		t_bus_rst();
		t_lps();
		t_cycle();
		finish_test();
	end
endmodule

`default_nettype wire
